//--- shared/ipc_defines.vh
// constants for the interrupt priority controller
`ifndef IPC_DEFINES_VH
`define IPC_DEFINES_VH
// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define IPC_OFS_LOW0 8'hb8
`define IPC_OFS_HIGH0 8'hb9
`define IPC_OFS_LOW3 8'hce
`define IPC_OFS_HIGH3 8'hcf
`define IPC_OFS_LOW1 8'he4
`define IPC_OFS_HIGH1 8'he5
`define IPC_OFS_LOW2 8'he6
`define IPC_OFS_HIGH2 8'he7
`define IPC_OFS_CTRL 8'hf0
`define IPC_OFS_FLAGS_LO 8'hf4
`define IPC_OFS_FLAGS_HI 8'hf8
`define IPC_OFS_STATUS 8'hfc
// ************************************************************
// implemented bit masks and reset values
// ************************************************************
`define IPC_MASK_LOW0 8'h7f
`define IPC_MASK_HIGH0 8'h3f
`define IPC_MASK_G1 8'h1f
`define IPC_MASK_G2 8'h02
`define IPC_MASK_G3 8'h0e
`define IPC_RST_PRIO 8'h00
// control register field positions
`define IPC_CTRL_GIE 0
`define IPC_CTRL_TYPE_A 1
`define IPC_CTRL_TYPE_B 2
// ************************************************************
// timing
// ************************************************************
`define IPC_LATENCY_CYC 2'h3
`endif

//--- hw/ipc_interrupt_priority_controller.v
// interrupt priority arbiter with avalon-mm priority registers
//
// What this block does
// - pending flags stay latched while another interrupt is in service.
// - no acknowledge while the stack is full; here only new takes are blocked.
// - vector jump follows a request only after several cycles latency.
// - each source has four levels from low and high priority bits.
// - level decode: 11 level 3, 10 level 2, 01 level 1, 00 level 0.
// - preemption only by strictly higher level than those in service.
// - at instruction boundary the highest pending level is chosen.
// - within a level the lowest vector address wins.
// - vector order only breaks ties, never overrides level.
// - vectors 0003, 000b, 0013, 001b, 0023 for the first five sources.
// - timer 2 at 002b, i2c 003b, capture units 0043 to 005b.
// - comparator 0063, adc 0073, time base 007b, low volt 008b last.
// - group 0 bits 0..5: ext a, tmr a, ext b, tmr b, serial, tmr c.
// - group 1 bits 0..3 capture units, bit 4 comparator, rest zero.
// - group 2 only bit 1, low voltage detect; others read zero.
// - group 3 bit 1 i2c, bit 2 adc, bit 3 time base; others zero.
// - external request on low level or falling edge unless stack full.
// - per-pin trigger type bit selects each external condition.
// - external request flag cleared by hardware when serviced.
// - trigger type 0 low level, 1 falling edge.
// - one global enable gates all requests besides source enables.
//
// usage notes
// - the core raises insn_boundary where it may branch; a winner is only
//   taken there, then shown three cycles later on irq_req and irq_vector.
// - irq_req stands until core_ack; the accepted source is pulsed on
//   irq_accepted for one cycle so auto-clearing flags can drop.
// - core_reti releases the highest level in service, one per pulse.
// - the choice is frozen at the take edge: a flag that goes away during
//   the latency is still presented, the core must cope with a stale slot.
// - stack_full only blocks new takes; a request already in flight stands.
// - the two pin flags live here; all other flags live in their sources.
// - reads of the register bus insert one wait state, writes none.
`timescale 1ns/100ps
`default_nettype none
`include "ipc_defines.vh"
module ipc_interrupt_priority_controller #(
  parameter NSRC = 15
) (
  // clock and reset
  input wire clock,
  input wire reset,
  // avalon-mm slave
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  output reg [1:0] avs_response,
  // external interrupt pins, active low
  input wire ext_irq_pin_a,
  input wire ext_irq_pin_b,
  // on-chip request flags and enables, bit order as vector order
  input wire [NSRC-1:0] src_request,
  input wire [NSRC-1:0] src_enable,
  // core handshake
  input wire stack_full,
  input wire insn_boundary,
  input wire core_ack,
  input wire core_reti,
  output reg irq_req,
  output reg [15:0] irq_vector,
  output reg [NSRC-1:0] irq_accepted,
  output reg [3:0] in_service
);
  // ************************************************************
  // registers
  // ************************************************************
  // priority bit pairs, unimplemented bits kept at zero
  reg [7:0] prio_low_group0_reg;
  reg [7:0] prio_high_group0_reg;
  reg [7:0] prio_low_group1_reg;
  reg [7:0] prio_high_group1_reg;
  reg [7:0] prio_low_group2_reg;
  reg [7:0] prio_high_group2_reg;
  reg [7:0] prio_low_group3_reg;
  reg [7:0] prio_high_group3_reg;
  // global enable and pin trigger types
  reg [2:0] ctrl_reg;
  // pin flags, two-flop synchronisers and edge history
  reg ext_a_flag_reg;
  reg ext_b_flag_reg;
  reg [1:0] sync_a_reg;
  reg [1:0] sync_b_reg;
  reg ext_a_prev_reg;
  reg ext_b_prev_reg;
  // bus read phase, latency count and latched winner
  reg rd_done_reg;
  reg [1:0] lat_cnt_reg;
  reg [3:0] win_idx_reg;
  wire global_irq_enable = ctrl_reg[`IPC_CTRL_GIE];
  wire ext_a_trigger_type = ctrl_reg[`IPC_CTRL_TYPE_A];
  wire ext_b_trigger_type = ctrl_reg[`IPC_CTRL_TYPE_B];
  wire ext_a_pin_s = sync_a_reg[1];
  wire ext_b_pin_s = sync_b_reg[1];
  // ************************************************************
  // bus decode
  // ************************************************************
  wire wr_en = avs_write & avs_byteenable[0];
  wire [7:0] wd = avs_writedata[7:0];
  // reads answer one cycle late, writes take immediately
  assign avs_waitrequest = avs_read & ~rd_done_reg;
  // ************************************************************
  // per-source priority bits, vector order
  // ************************************************************
  wire [NSRC-1:0] plo = {prio_low_group2_reg[1], prio_low_group3_reg[3:2],
    prio_low_group1_reg[4:0], prio_low_group3_reg[1],
    prio_low_group0_reg[5:0]};
  wire [NSRC-1:0] phi = {prio_high_group2_reg[1], prio_high_group3_reg[3:2],
    prio_high_group1_reg[4:0], prio_high_group3_reg[1],
    prio_high_group0_reg[5:0]};
  // external flags replace inputs 0 and 2
  wire [NSRC-1:0] flags = {src_request[NSRC-1:3], ext_b_flag_reg,
    src_request[1], ext_a_flag_reg};
  wire [NSRC-1:0] pend = flags & src_enable
    & {NSRC{global_irq_enable}};
  // vector lookup in tie-break order; the index is the source's slot,
  // so a lower index always means a lower vector address
  // vector lookup in tie-break order
  function [15:0] vec_of;
    input [3:0] i;
    begin
      case (i)
        4'h0: vec_of = 16'h0003;
        4'h1: vec_of = 16'h000b;
        4'h2: vec_of = 16'h0013;
        4'h3: vec_of = 16'h001b;
        4'h4: vec_of = 16'h0023;
        4'h5: vec_of = 16'h002b;
        4'h6: vec_of = 16'h003b;
        4'h7: vec_of = 16'h0043;
        4'h8: vec_of = 16'h004b;
        4'h9: vec_of = 16'h0053;
        4'ha: vec_of = 16'h005b;
        4'hb: vec_of = 16'h0063;
        4'hc: vec_of = 16'h0073;
        4'hd: vec_of = 16'h007b;
        default: vec_of = 16'h008b;
      endcase
    end
  endfunction
  // ************************************************************
  // arbitration: best level, then lowest index
  // ************************************************************
  reg [1:0] best_lvl;
  reg [3:0] best_idx;
  reg best_any;
  reg [1:0] lvl;
  integer i;
  // walk from the last slot down: an equal level met later belongs to a
  // lower vector and replaces the earlier pick, a lower level never does,
  // so slot order only splits ties
  always @* begin
    best_lvl = 2'd0;
    best_idx = 4'd0;
    best_any = 1'b0;
    lvl = 2'd0;
    for (i = NSRC - 1; i >= 0; i = i - 1) begin
      lvl = {phi[i], plo[i]};
      // higher level always wins; equal level prefers lower index
      if (pend[i] && (!best_any || lvl >= best_lvl)) begin
        best_lvl = lvl;
        best_idx = i[3:0];
        best_any = 1'b1;
      end
    end
  end
  // highest level currently in service; svc_any low and svc_top 0 when none
  wire svc_any = |in_service;
  wire [1:0] svc_top = in_service[3] ? 2'd3 : in_service[2] ? 2'd2 :
    in_service[1] ? 2'd1 : 2'd0;
  wire can_preempt = best_any & (!svc_any || best_lvl > svc_top);
  // one take at a time: nothing new while a request is in flight or the
  // latency runs, so the vector cannot change under the core; a full stack
  // leaves every flag latched for later
  wire take = can_preempt & insn_boundary & ~stack_full
    & ~irq_req & (lat_cnt_reg == 2'd0);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  // reset to the idle high level of the pins so that no false falling
  // edge is seen right after reset
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_a_reg <= 2'b11;
      sync_b_reg <= 2'b11;
      ext_a_prev_reg <= 1'b1;
      ext_b_prev_reg <= 1'b1;
    end else begin
      sync_a_reg <= {sync_a_reg[0], ext_irq_pin_a};
      sync_b_reg <= {sync_b_reg[0], ext_irq_pin_b};
      ext_a_prev_reg <= ext_a_pin_s;
      ext_b_prev_reg <= ext_b_pin_s;
    end
  end
  // external trigger conditions; level mode keeps setting the flag for
  // as long as the pin stays low, even right after service
  wire ext_a_hit = ext_a_trigger_type ? (ext_a_prev_reg & ~ext_a_pin_s)
    : ~ext_a_pin_s;
  wire ext_b_hit = ext_b_trigger_type ? (ext_b_prev_reg & ~ext_b_pin_s)
    : ~ext_b_pin_s;
  // pin flags clear themselves on the acknowledge of their own slot only
  wire ack_a = core_ack & irq_req & (win_idx_reg == 4'd0);
  wire ack_b = core_ack & irq_req & (win_idx_reg == 4'd2);
  // ************************************************************
  // external flags: set wins over clear
  // ************************************************************
  // an edge in the acknowledge cycle must not be lost, hence the set
  // branch comes first
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      ext_a_flag_reg <= 1'b0;
      ext_b_flag_reg <= 1'b0;
    end else begin
      if (ext_a_hit)
        ext_a_flag_reg <= 1'b1;
      else if (ack_a)
        ext_a_flag_reg <= 1'b0;
      if (ext_b_hit)
        ext_b_flag_reg <= 1'b1;
      else if (ack_b)
        ext_b_flag_reg <= 1'b0;
    end
  end
  // ************************************************************
  // request, latency and in-service tracking
  // ************************************************************
  reg [3:0] svc_clear;
  // a return releases only the highest level in service, the one whose
  // routine is ending
  always @* begin
    svc_clear = 4'd0;
    if (core_reti) begin
      if (in_service[3]) svc_clear = 4'b1000;
      else if (in_service[2]) svc_clear = 4'b0100;
      else if (in_service[1]) svc_clear = 4'b0010;
      else svc_clear = {3'b000, in_service[0]};
    end
  end
  reg [1:0] win_lvl_reg;
  // take, count down the latency, present the vector, then retire it on
  // the acknowledge and mark its level in service; a return in the same
  // cycle as an acknowledge still releases the older level
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      irq_req <= 1'b0;
      irq_vector <= 16'h0000;
      irq_accepted <= {NSRC{1'b0}};
      in_service <= 4'd0;
      lat_cnt_reg <= 2'd0;
      win_idx_reg <= 4'd0;
      win_lvl_reg <= 2'd0;
    end else begin
      irq_accepted <= {NSRC{1'b0}};
      in_service <= in_service & ~svc_clear;
      if (take) begin
        // hold the choice through a short latency
        lat_cnt_reg <= `IPC_LATENCY_CYC;
        win_idx_reg <= best_idx;
        win_lvl_reg <= best_lvl;
      end else if (lat_cnt_reg != 2'd0) begin
        lat_cnt_reg <= lat_cnt_reg - 2'd1;
        if (lat_cnt_reg == 2'd1) begin
          irq_req <= 1'b1;
          irq_vector <= vec_of(win_idx_reg);
        end
      end else if (irq_req && core_ack) begin
        irq_req <= 1'b0;
        irq_accepted <= {{(NSRC-1){1'b0}}, 1'b1} << win_idx_reg;
        in_service <= (in_service & ~svc_clear)
          | (4'b0001 << win_lvl_reg);
      end
    end
  end
  // ************************************************************
  // register writes
  // ************************************************************
  // byte lane 0 only; unmapped addresses and the read-only flag and
  // status words fall through without effect
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      prio_low_group0_reg <= `IPC_RST_PRIO;
      prio_high_group0_reg <= `IPC_RST_PRIO;
      prio_low_group1_reg <= `IPC_RST_PRIO;
      prio_high_group1_reg <= `IPC_RST_PRIO;
      prio_low_group2_reg <= `IPC_RST_PRIO;
      prio_high_group2_reg <= `IPC_RST_PRIO;
      prio_low_group3_reg <= `IPC_RST_PRIO;
      prio_high_group3_reg <= `IPC_RST_PRIO;
      ctrl_reg <= 3'd0;
    end else if (wr_en) begin
      if (avs_address == `IPC_OFS_LOW0)
        prio_low_group0_reg <= wd & `IPC_MASK_LOW0;
      else if (avs_address == `IPC_OFS_HIGH0)
        prio_high_group0_reg <= wd & `IPC_MASK_HIGH0;
      else if (avs_address == `IPC_OFS_LOW1)
        prio_low_group1_reg <= wd & `IPC_MASK_G1;
      else if (avs_address == `IPC_OFS_HIGH1)
        prio_high_group1_reg <= wd & `IPC_MASK_G1;
      else if (avs_address == `IPC_OFS_LOW2)
        prio_low_group2_reg <= wd & `IPC_MASK_G2;
      else if (avs_address == `IPC_OFS_HIGH2)
        prio_high_group2_reg <= wd & `IPC_MASK_G2;
      else if (avs_address == `IPC_OFS_LOW3)
        prio_low_group3_reg <= wd & `IPC_MASK_G3;
      else if (avs_address == `IPC_OFS_HIGH3)
        prio_high_group3_reg <= wd & `IPC_MASK_G3;
      else if (avs_address == `IPC_OFS_CTRL)
        ctrl_reg <= wd[2:0];
    end
  end
  // ************************************************************
  // register reads
  // ************************************************************
  // unmapped reads return zero with an error response
  reg [7:0] rd_mux;
  reg rd_hit;
  always @* begin
    rd_mux = 8'h00;
    rd_hit = 1'b1;
    if (avs_address == `IPC_OFS_LOW0)
      rd_mux = prio_low_group0_reg;
    else if (avs_address == `IPC_OFS_HIGH0)
      rd_mux = prio_high_group0_reg;
    else if (avs_address == `IPC_OFS_LOW1)
      rd_mux = prio_low_group1_reg;
    else if (avs_address == `IPC_OFS_HIGH1)
      rd_mux = prio_high_group1_reg;
    else if (avs_address == `IPC_OFS_LOW2)
      rd_mux = prio_low_group2_reg;
    else if (avs_address == `IPC_OFS_HIGH2)
      rd_mux = prio_high_group2_reg;
    else if (avs_address == `IPC_OFS_LOW3)
      rd_mux = prio_low_group3_reg;
    else if (avs_address == `IPC_OFS_HIGH3)
      rd_mux = prio_high_group3_reg;
    else if (avs_address == `IPC_OFS_CTRL)
      rd_mux = {5'd0, ctrl_reg};
    else if (avs_address == `IPC_OFS_FLAGS_LO)
      rd_mux = flags[7:0];
    else if (avs_address == `IPC_OFS_FLAGS_HI)
      rd_mux = {1'b0, flags[NSRC-1:8]};
    else if (avs_address == `IPC_OFS_STATUS)
      rd_mux = {irq_req, stack_full, best_lvl, in_service};
    else
      rd_hit = 1'b0;
  end
  // read data registered, waitrequest drops the cycle after; rd_done
  // toggles, so a held read completes every second cycle and back to back
  // reads need no idle edge in between
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      rd_done_reg <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_response <= 2'b00;
    end else begin
      rd_done_reg <= avs_read & ~rd_done_reg;
      if (avs_read && !rd_done_reg) begin
        avs_readdata <= {24'h00_0000, rd_mux};
        avs_response <= rd_hit ? 2'b00 : 2'b10;
      end
    end
  end
endmodule
`default_nettype wire

//--- test/ipc_checker_assertions.sv
// port checker for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
module ipc_checker #(
  parameter NSRC = 15
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // register bus
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire logic [1:0] avs_response,
  // sources
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic [NSRC-1:0] src_request,
  input wire logic [NSRC-1:0] src_enable,
  // core handshake
  input wire logic stack_full,
  input wire logic insn_boundary,
  input wire logic core_ack,
  input wire logic core_reti,
  input wire logic irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic [NSRC-1:0] irq_accepted,
  input wire logic [3:0] in_service
);
  logic [3:0] sf_cnt_reg;
  // ************************************************************
  // helper: cycles the stack has stayed full
  // ************************************************************
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      sf_cnt_reg <= 4'h0;
    end else begin
      if (!stack_full)
        sf_cnt_reg <= 4'h0;
      else if (sf_cnt_reg != 4'hf)
        sf_cnt_reg <= sf_cnt_reg + 4'h1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ************************************************************
  // assertions
  // ************************************************************
  req_stands_a: assert property (
    irq_req && !core_ack |=> irq_req && $stable(irq_vector))
    else $error("request or vector moved before acknowledge");
  ack_drops_a: assert property (
    irq_req && core_ack |=> !irq_req && $onehot(irq_accepted))
    else $error("acknowledge did not retire the request");
  accept_cause_a: assert property (
    irq_accepted != 0 |-> $past(irq_req && core_ack))
    else $error("accepted pulse without acknowledge");
  gap_after_a: assert property (
    irq_req && core_ack |=> !irq_req [*2])
    else $error("new request came back too soon");
  stack_hold_a: assert property (
    sf_cnt_reg >= 4'h6 |-> !$rose(irq_req))
    else $error("request raised while stack full");
  boundary_take_a: assert property (
    $rose(irq_req) |-> $past(insn_boundary && !stack_full, 4))
    else $error("request not taken at a boundary");
  vec_form_a: assert property (
    irq_req |-> irq_vector[2:0] == 3'b011 && irq_vector[15:8] == 8'h00)
    else $error("vector outside the table");
  preempt_up_a: assert property (
    irq_accepted != 0 |->
      (in_service ^ $past(in_service)) > $past(in_service))
    else $error("accepted level not above levels in service");
  reti_clear_a: assert property (
    core_reti && $onehot(in_service) && !(irq_req && core_ack)
      |=> in_service == 4'h0)
    else $error("return left a level in service");
  // covers
  nest_c: cover property (irq_accepted != 0 && $past(in_service) != 0);
  stack_c: cover property (sf_cnt_reg >= 4'h6 && src_request != 0);
  reti_c: cover property (core_reti && in_service != 0);
endmodule
`default_nettype wire

//--- test/ipc_core_model.sv
// core and peripheral flag model facing the controller
`timescale 1ns/100ps
`default_nettype none
module ipc_core_model #(
  parameter ACK_DELAY = 4
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // controller side
  input wire logic irq_req,
  input wire logic [14:0] irq_accepted,
  output logic core_ack,
  output logic [14:0] src_request,
  // bench side
  input wire logic [14:0] raise
);
  logic [3:0] wait_reg;
  // peripheral flags stay set until their source is accepted
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      src_request <= 15'h0000;
    end else begin
      src_request <= (src_request & ~irq_accepted) | raise;
    end
  end
  // core takes the vector after a fixed wait, one-cycle pulse
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      wait_reg <= 4'h0;
      core_ack <= 1'b0;
    end else begin
      core_ack <= irq_req && !core_ack && (wait_reg == ACK_DELAY);
      wait_reg <= (irq_req && !core_ack) ? wait_reg + 4'h1 : 4'h0;
    end
  end
endmodule
`default_nettype wire

//--- test/tb_interrupt_priority_controller.sv
// bench for the interrupt priority controller
`timescale 1ns/100ps
`default_nettype none
module tb_interrupt_priority_controller;
  logic clock = 0, reset = 1, avs_read = 0, avs_write = 0, avs_waitrequest;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [1:0] avs_response, rs;
  logic pin_a = 1, pin_b = 1, stack_full = 0, core_reti = 0;
  logic insn_boundary = 1, core_ack, irq_req;
  logic [14:0] src_request, irq_accepted, raise = 15'h0000;
  logic [15:0] irq_vector;
  logic [3:0] in_service;
  int miscompares = 0, total_checks = 0;
  logic [7:0] offs [8] = '{8'hb8, 8'hb9, 8'he4, 8'he5,
    8'he6, 8'he7, 8'hce, 8'hcf};
  logic [7:0] msk [8] = '{8'h7f, 8'h3f, 8'h1f, 8'h1f,
    8'h02, 8'h02, 8'h0e, 8'h0e};
  always #50 clock = ~clock;
  ipc_interrupt_priority_controller dut (.clock(clock), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .ext_irq_pin_a(pin_a), .ext_irq_pin_b(pin_b),
    .src_request(src_request), .src_enable(15'h7fff), .stack_full(stack_full),
    .insn_boundary(insn_boundary), .core_ack(core_ack),
    .core_reti(core_reti),
    .irq_req(irq_req), .irq_vector(irq_vector), .irq_accepted(irq_accepted),
    .in_service(in_service));
  ipc_core_model core (.clock(clock), .reset(reset), .irq_req(irq_req),
    .irq_accepted(irq_accepted), .core_ack(core_ack),
    .src_request(src_request), .raise(raise));
  // ************************************************************
  // access and compare tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] exp, got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    avs_write <= 1'b0;
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    @(posedge clock);
    avs_address <= a;
    avs_read <= 1'b1;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    d = avs_readdata;
    r = avs_response;
    avs_read <= 1'b0;
  endtask
  task automatic fire(input logic [14:0] b);
    @(posedge clock);
    raise <= b;
    @(posedge clock);
    raise <= 15'h0000;
  endtask
  task automatic svc(input logic [15:0] v, input logic [14:0] b);
    @(posedge clock);
    while (irq_req !== 1'b1) @(posedge clock);
    chk("irq_vector", {16'h0000, v}, {16'h0000, irq_vector});
    while (irq_accepted === 15'h0000) @(posedge clock);
    chk("irq_accepted", {17'h0_0000, b}, {17'h0_0000, irq_accepted});
  endtask
  task automatic reti;
    @(posedge clock);
    core_reti <= 1'b1;
    @(posedge clock);
    core_reti <= 1'b0;
  endtask
  task automatic quiet;
    logic seen;
    seen = 0;
    repeat (12) begin
      @(posedge clock);
      if (irq_req !== 1'b0) seen = 1;
    end
    chk("irq_quiet", 32'h0000_0000, {31'h0000_0000, seen});
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (3) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus_rd(offs[i], rd, rs);
      chk("prio_reset", 32'h0000_0000, rd);
      bus_wr(offs[i], 8'hff);
      bus_rd(offs[i], rd, rs);
      chk("prio_mask", {24'h00_0000, msk[i]}, rd);
      bus_wr(offs[i], 8'h00);
    end
    bus_rd(8'h10, rd, rs);
    chk("unmapped_resp", 32'h0000_0002, {30'h0000_0000, rs});
    fire(15'h0002);
    quiet();
    bus_wr(8'hf0, 8'h01);
    svc(16'h000b, 15'h0002);
    reti();
    fire(15'h0012);
    svc(16'h000b, 15'h0002);
    reti();
    svc(16'h0023, 15'h0010);
    reti();
    bus_wr(8'he6, 8'h02);
    bus_wr(8'he7, 8'h02);
    fire(15'h4002);
    svc(16'h008b, 15'h4000);
    reti();
    svc(16'h000b, 15'h0002);
    reti();
    bus_wr(8'hce, 8'h04);
    bus_wr(8'he5, 8'h01);
    fire(15'h1000);
    svc(16'h0073, 15'h1000);
    fire(15'h0002);
    quiet();
    bus_rd(8'hf4, rd, rs);
    chk("flags_lo", 32'h0000_0002, rd);
    fire(15'h0080);
    svc(16'h0043, 15'h0080);
    chk("in_service", 32'h0000_0006, {28'h000_0000, in_service});
    bus_rd(8'hfc, rd, rs);
    chk("status", 32'h0000_0006, rd);
    reti();
    reti();
    svc(16'h000b, 15'h0002);
    reti();
    stack_full <= 1'b1;
    fire(15'h0010);
    quiet();
    stack_full <= 1'b0;
    svc(16'h0023, 15'h0010);
    reti();
    bus_wr(8'hf0, 8'h03);
    pin_a <= 1'b0;
    repeat (3) @(posedge clock);
    pin_a <= 1'b1;
    svc(16'h0003, 15'h0001);
    reti();
    quiet();
    bus_wr(8'hf0, 8'h01);
    pin_b <= 1'b0;
    repeat (3) @(posedge clock);
    pin_b <= 1'b1;
    svc(16'h0013, 15'h0004);
    reti();
    quiet();
    insn_boundary <= 1'b0;
    fire(15'h0008);
    quiet();
    insn_boundary <= 1'b1;
    svc(16'h001b, 15'h0008);
    reti();
    tally_and_finish();
  end
  // watchdog
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
endmodule
bind ipc_interrupt_priority_controller ipc_checker #(.NSRC(NSRC)) chk_i (
  .clock(clock), .reset(reset), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .ext_irq_pin_a(ext_irq_pin_a), .ext_irq_pin_b(ext_irq_pin_b),
  .src_request(src_request), .src_enable(src_enable),
  .stack_full(stack_full), .insn_boundary(insn_boundary),
  .core_ack(core_ack), .core_reti(core_reti), .irq_req(irq_req),
  .irq_vector(irq_vector), .irq_accepted(irq_accepted),
  .in_service(in_service));
`default_nettype wire
